// file: logic/see_defines.svh
// Constants shared by both ends of the two-wire EEPROM link.
`ifndef SEE_DEFINES_SVH
`define SEE_DEFINES_SVH
// The device code value is arbitrary; both ends take it from here.
`define SEE_DEV_CODE     4'h5
`define SEE_MEM_DEPTH    128
`define SEE_PAGE_BYTES   16
`define SEE_PROT_BASE    7'h40
`define SEE_CLK_MHZ      25
`define SEE_WRITE_US     5
`define SEE_WRITE_CYC    (`SEE_WRITE_US * `SEE_CLK_MHZ)
// The half bit must outlast the device's five-clock pin-to-pin delay (sync, decision, drive).
`define SEE_HALF_BIT_NS  400
`define SEE_HALF_BIT_CYC (`SEE_HALF_BIT_NS * `SEE_CLK_MHZ / 1000)
`endif

// file: logic/see_pkg.sv
// Types shared by both ends of the two-wire EEPROM link.
package see_pkg;
	typedef logic [6:0] see_addr_t;
	typedef logic [7:0] see_byte_t;
endpackage : see_pkg

// file: logic/see_link_if.sv
// Two-wire link between the bus master and the EEPROM device.
`timescale 1ns/1ps
interface see_link_if;
	logic scl;
	logic sda_m_out;
	logic sda_m_oe;
	logic sda_d_out;
	logic sda_d_oe;
	logic sda;
	assign sda = !((sda_m_oe && !sda_m_out) || (sda_d_oe && !sda_d_out));
	modport device (input scl, input sda, output sda_d_out, output sda_d_oe);
	modport master (output scl, input sda, output sda_m_out, output sda_m_oe);
endinterface : see_link_if

// file: logic/see_device.sv
// EEPROM device end: command logic, page buffer, array and write timer.
// Operation
// - Control byte: code, selects, R/W; ack
// - Write: next byte loads address pointer
// - Ack data; stop starts write cycle
// - Busy: acknowledge nothing, not even control
// - Protected write acked but array unchanged
// - Master waits write time even if protected
// - Up to sixteen bytes buffered, committed at stop
// - Page write increments low four bits
// - Over sixteen bytes overwrite buffered ones
// - Writes wrap within sixteen-byte page
// - Protect high blocks 40h to 7Fh
// - Master polls with write control byte
// - Polling may start right after stop
// - R/W one selects read
// - Current read uses held address counter
// - Repeated start keeps pointer, serves read
// - No ack plus stop ends read
// - Counter points past last byte read
// - Master ack requests next byte
// - Read pointer wraps 7Fh to 00h
// - Respond only on code and select match
`timescale 1ns/1ps
`include "see_defines.svh"
module see_device #(
	parameter int WRITE_CYC = `SEE_WRITE_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	see_link_if.device link,
	input  wire logic chip_select_bit_zero,
	input  wire logic chip_select_bit_one,
	input  wire logic chip_select_bit_two,
	input  wire logic write_protect,
	output logic      busy
);
	import see_pkg::*;

	typedef enum logic [4:0] {
		SEE_IDLE = 5'h01, SEE_RX = 5'h02, SEE_ACK = 5'h04, SEE_TX = 5'h08, SEE_MACK = 5'h10
	} see_state_e;

	// ==============================================
	// Pin sampling
	logic [2:0]  scl_q;
	logic [2:0]  sda_q;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
			scl_s <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			scl_q <= {scl_q[1:0], link.scl};
			sda_q <= {sda_q[1:0], link.sda};
			// A change counts only once the two later stages agree.
			if (scl_q[1] == scl_q[2])
				scl_s <= scl_q[2];
			if (sda_q[1] == sda_q[2])
				sda_s <= sda_q[2];
		end
	end
	logic scl_n;
	logic sda_n;
	assign scl_n    = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_s;
	assign sda_n    = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_s;
	assign scl_rise = scl_n && !scl_s;
	assign scl_fall = !scl_n && scl_s;
	assign start_c  = scl_s && scl_n && sda_s && !sda_n;
	assign stop_c   = scl_s && scl_n && !sda_s && sda_n;

	// ==============================================
	// Protocol engine
	see_state_e  state;
	logic [3:0]  bit_cnt;
	see_byte_t   shreg;
	logic [1:0]  byte_idx;
	logic        rd_mode;
	logic        ack_ok;
	logic        wr_pend;
	see_addr_t   ptr;
	see_byte_t   mem [`SEE_MEM_DEPTH];
	see_byte_t   page [`SEE_PAGE_BYTES];
	logic [15:0] page_vld;
	see_addr_t   page_base;
	logic [31:0] wr_timer;
	logic        commit;
	logic        sda_oe;

	function automatic logic ctrl_match(input see_byte_t b, input logic [2:0] cs);
		ctrl_match = (b[7:4] == `SEE_DEV_CODE) && (b[3:1] == cs);
	endfunction : ctrl_match

	function automatic logic prot_hit(input see_addr_t a, input logic wp);
		prot_hit = wp && (a >= `SEE_PROT_BASE);
	endfunction : prot_hit

	// Busy withholds every acknowledge, the control byte's included.
	assign ack_ok = !busy && (byte_idx != 2'h0 || ctrl_match(shreg, {chip_select_bit_two,
		chip_select_bit_one, chip_select_bit_zero}));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= SEE_IDLE;
			bit_cnt  <= 4'h0;
			shreg    <= 8'h00;
			byte_idx <= 2'h0;
			rd_mode  <= 1'b0;
			wr_pend  <= 1'b0;
			ptr      <= 7'h00;
			page_vld <= 16'h0000;
			page_base <= 7'h00;
			sda_oe   <= 1'b0;
			commit   <= 1'b0;
		end else begin
			commit <= 1'b0;
			if (stop_c) begin
				state  <= SEE_IDLE;
				sda_oe <= 1'b0;
				if (wr_pend && page_vld != 16'h0000)
					commit <= 1'b1;
				wr_pend <= 1'b0;
			end else if (start_c) begin
				// Repeated start abandons the write but keeps the pointer.
				state    <= SEE_RX;
				bit_cnt  <= 4'h0;
				byte_idx <= 2'h0;
				wr_pend  <= 1'b0;
				page_vld <= 16'h0000;
				sda_oe   <= 1'b0;
			end else begin
				unique case (state)
				SEE_IDLE: begin
					sda_oe <= 1'b0;
				end
				SEE_RX: if (scl_rise) begin
					shreg   <= {shreg[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (scl_fall && bit_cnt == 4'h8) begin
					bit_cnt <= 4'h0;
					if (byte_idx == 2'h0)
						rd_mode <= shreg[0];
					if (ack_ok) begin
						state  <= SEE_ACK;
						sda_oe <= 1'b1;
						if (byte_idx == 2'h1) begin
							ptr       <= shreg[6:0];
							page_base <= shreg[6:0];
							wr_pend   <= 1'b1;
						end else if (byte_idx == 2'h2) begin
							page[ptr[3:0]]     <= shreg;
							page_vld[ptr[3:0]] <= 1'b1;
							ptr <= {ptr[6:4], ptr[3:0] + 4'h1};
						end
						if (byte_idx != 2'h2)
							byte_idx <= byte_idx + 2'h1;
					end else begin
						state <= SEE_IDLE;
					end
				end
				SEE_ACK: if (scl_fall) begin
					if (rd_mode) begin
						state   <= SEE_TX;
						shreg   <= mem[ptr];
						ptr     <= ptr + 7'h01;
						sda_oe  <= !mem[ptr][7];
						bit_cnt <= 4'h1;
					end else begin
						state  <= SEE_RX;
						sda_oe <= 1'b0;
					end
				end
				SEE_TX: if (scl_fall) begin
					if (bit_cnt == 4'h8) begin
						state  <= SEE_MACK;
						sda_oe <= 1'b0;
					end else begin
						sda_oe  <= !shreg[7 - bit_cnt[2:0]];
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				SEE_MACK: if (scl_rise) begin
					// Master ack asks for the next byte; no ack ends the read.
					state <= sda_s ? SEE_IDLE : SEE_ACK;
				end
				default: state <= SEE_IDLE;
				endcase
			end
		end
	end

	// ==============================================
	// Array commit and self-timed write
	always_ff @(posedge clk) begin
		if (commit) begin
			for (int i = 0; i < `SEE_PAGE_BYTES; i++) begin
				if (page_vld[i] && !prot_hit({page_base[6:4], 4'(i)}, write_protect))
					mem[{page_base[6:4], 4'(i)}] <= page[i];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy     <= 1'b0;
			wr_timer <= 32'h0;
		end else if (commit) begin
			busy     <= 1'b1;
			wr_timer <= 32'(WRITE_CYC - 1);
		end else if (busy) begin
			if (wr_timer == 32'h0)
				busy <= 1'b0;
			else
				wr_timer <= wr_timer - 32'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			link.sda_d_oe  <= 1'b0;
			link.sda_d_out <= 1'b1;
		end else begin
			link.sda_d_oe  <= sda_oe;
			link.sda_d_out <= 1'b0;
		end
	end
endmodule : see_device

// file: logic/see_master.sv
// Bus master end: clock divider and command sequencer for one byte transfer.
`timescale 1ns/1ps
`include "see_defines.svh"
module see_master (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	see_link_if.master            link,
	input  wire logic             cmd_valid,
	input  wire logic             cmd_read,
	input  wire logic [2:0]       cmd_select,
	input  wire see_pkg::see_addr_t cmd_addr,
	input  wire see_pkg::see_byte_t cmd_wdata,
	output logic                  cmd_ready,
	output logic                  rsp_valid,
	output logic                  rsp_nack,
	output see_pkg::see_byte_t    rsp_rdata
);
	import see_pkg::*;

	typedef enum logic [3:0] {
		SEM_IDLE = 4'h1, SEM_START = 4'h2, SEM_BITS = 4'h4, SEM_STOP = 4'h8
	} see_mstate_e;

	// ==============================================
	// Half-bit tick
	logic [7:0] div;
	logic       tick;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			div <= 8'h00;
		else
			div <= tick ? 8'h00 : div + 8'h01;
	end
	assign tick = (div == 8'(`SEE_HALF_BIT_CYC - 1));

	// ==============================================
	// Sequencer: every byte is 9 clocks; ninth is ack.
	see_mstate_e st;
	logic [1:0]  nbytes;
	logic [1:0]  bidx;
	logic [3:0]  bcnt;
	logic        phase;
	logic [7:0]  tx [3];
	logic [7:0]  rx;
	logic        is_rd;

	// Drive for one bit slot as {enable, level}. The ninth slot of a written byte is
	// released for the device's acknowledge; that of the read byte carries the no-ack.
	function automatic logic [1:0] bit_drive(input logic [1:0] bi, input logic [3:0] bc,
		input logic rdm, input see_byte_t b);
		if (rdm && bi == 2'h1)
			bit_drive = (bc == 4'h8) ? 2'b11 : 2'b01;
		else if (bc == 4'h8)
			bit_drive = 2'b01;
		else
			bit_drive = {1'b1, b[3'h7 - bc[2:0]]};
	endfunction : bit_drive
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= SEM_IDLE; link.scl <= 1'b1; link.sda_m_oe <= 1'b0;
			link.sda_m_out <= 1'b1; cmd_ready <= 1'b1; rsp_valid <= 1'b0;
			rsp_nack <= 1'b0; rsp_rdata <= 8'h00; nbytes <= 2'h0; bidx <= 2'h0;
			bcnt <= 4'h0; phase <= 1'b0; rx <= 8'h00; is_rd <= 1'b0;
			tx[0] <= 8'h00; tx[1] <= 8'h00; tx[2] <= 8'h00;
		end else begin
			rsp_valid <= 1'b0;
			unique case (st)
			SEM_IDLE: if (cmd_valid) begin
				// Control byte: write code for writes, read code for current reads.
				tx[0]  <= {`SEE_DEV_CODE, cmd_select, cmd_read};
				tx[1]  <= {1'b0, cmd_addr};
				tx[2]  <= cmd_wdata;
				nbytes <= cmd_read ? 2'h2 : 2'h3;
				is_rd  <= cmd_read;
				phase  <= 1'b0;
				cmd_ready <= 1'b0;
				st <= SEM_START;
			end
			SEM_START: if (tick) begin
				phase <= !phase;
				if (!phase) begin
					// Start: data falls while the clock is still high.
					link.sda_m_oe <= 1'b1;
					link.sda_m_out <= 1'b0;
					bidx <= 2'h0;
					bcnt <= 4'h0;
					rsp_nack <= 1'b0;
				end else begin
					link.scl <= 1'b0;
					{link.sda_m_oe, link.sda_m_out} <= bit_drive(2'h0, 4'h0, is_rd, tx[0]);
					st <= SEM_BITS;
				end
			end
			// The bus is sampled at the end of each high half, long after the device's
			// synchroniser delay; our data changes only together with the falling clock.
			SEM_BITS: if (tick) begin
				phase <= !phase;
				if (!phase) begin
					link.scl <= 1'b1;
				end else if (bcnt == 4'h8) begin
					bcnt <= 4'h0;
					if (bidx == 2'h0 && link.sda) begin
						rsp_nack <= 1'b1;
						st <= SEM_STOP;
					end else if (bidx == nbytes - 2'h1) begin
						st <= SEM_STOP;
					end else begin
						bidx <= bidx + 2'h1;
						link.scl <= 1'b0;
						{link.sda_m_oe, link.sda_m_out} <= bit_drive(bidx + 2'h1, 4'h0,
							is_rd, tx[bidx + 2'h1]);
					end
				end else begin
					if (is_rd && bidx == 2'h1)
						rx <= {rx[6:0], link.sda};
					bcnt <= bcnt + 4'h1;
					link.scl <= 1'b0;
					{link.sda_m_oe, link.sda_m_out} <= bit_drive(bidx, bcnt + 4'h1,
						is_rd, tx[bidx]);
				end
			end
			SEM_STOP: if (tick) begin
				bcnt <= bcnt + 4'h1;
				if (bcnt == 4'h0) begin
					link.scl <= 1'b0;
					link.sda_m_oe <= 1'b1;
					link.sda_m_out <= 1'b0;
				end else if (bcnt == 4'h1) begin
					link.scl <= 1'b1;
				end else begin
					// Stop: data rises while the clock is high.
					link.sda_m_oe <= 1'b0;
					link.sda_m_out <= 1'b1;
					rsp_rdata <= rx;
					rsp_valid <= 1'b1;
					cmd_ready <= 1'b1;
					st <= SEM_IDLE;
				end
			end
			default: st <= SEM_IDLE;
			endcase
		end
	end
endmodule : see_master

// file: sim/see_link_asserts.sv
// Checker for the two-wire link between the master and device ends.
`timescale 1ns/1ps
`include "see_defines.svh"
module see_link_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_out,
	input wire logic sda_m_oe,
	input wire logic sda_d_out,
	input wire logic sda_d_oe
);
	// ====
	// Frame and bit tracking
	logic       scl_q, sda_q, in_frame, first, rd;
	logic [3:0] cnt;
	logic [7:0] shreg;
	wire        dev_pull = sda_d_oe && !sda_d_out;
	wire        m_pull   = sda_m_oe && !sda_m_out;
	wire        start_ev = scl && scl_q && sda_q && !sda;
	wire        stop_ev  = scl && scl_q && !sda_q && sda;
	wire        rise     = in_frame && scl && !scl_q;
	// The count runs 1..9 per byte, so slot 9 is the acknowledge clock.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			in_frame <= 1'b0;
			first    <= 1'b0;
			rd       <= 1'b0;
			cnt      <= 4'h0;
			shreg    <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_ev) begin
				in_frame <= 1'b1;
				first    <= 1'b1;
				rd       <= 1'b0;
				cnt      <= 4'h0;
			end else if (stop_ev) begin
				in_frame <= 1'b0;
			end else if (rise) begin
				cnt   <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
				shreg <= {shreg[6:0], sda};
				if (cnt == 4'h8) first <= 1'b0;
				if (first && cnt == 4'h7) rd <= sda;
			end
		end
	end
	// ====
	// Link properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence start_s;
		scl && $fell(sda);
	endsequence
	sequence stop_s;
		scl && $rose(sda);
	endsequence
	frame_close_a: assert property (start_s |-> ##[1:800] stop_s)
		else $error("frame not closed by a stop");
	scl_idle_a: assert property (!in_frame |-> scl)
		else $error("clock low outside a frame");
	dev_idle_a: assert property (!in_frame |-> !dev_pull)
		else $error("device drives outside a frame");
	dev_stable_a: assert property (scl && scl_q |-> $stable(dev_pull))
		else $error("device data moved while clock high");
	master_stable_a: assert property (scl && scl_q && cnt inside {[2:8]}
		|-> $stable(m_pull)) else $error("master data moved while clock high");
	code_match_a: assert property (rise && first && cnt == 4'h8 && !sda
		|-> shreg[7:4] == `SEE_DEV_CODE) else $error("foreign code acknowledged");
	write_quiet_a: assert property (rise && (first || !rd) && cnt inside {[1:7]}
		|-> !dev_pull) else $error("device drives during a received bit");
	read_release_a: assert property (rise && rd && !first && cnt == 4'h8
		|-> !dev_pull) else $error("device holds the master acknowledge slot");
endmodule : see_link_asserts

// file: sim/serial_eeprom_command_logic_tb.sv
// Bench joining the master and device ends over the two-wire link.
`timescale 1ns/1ps
module serial_eeprom_command_logic_tb;
	import see_pkg::*;
	// ====
	// Setup
	localparam int         WCYC = 300;
	localparam logic [2:0] CS   = 3'b101;
	logic       clk, sys_rst, wp, busy, cmd_valid, cmd_read, cmd_ready;
	logic       rsp_valid, rsp_nack;
	logic [2:0] cmd_select;
	see_addr_t  cmd_addr;
	see_byte_t  cmd_wdata, rsp_rdata;
	int         n_fail, checks;
	see_link_if link ();
	see_device #(.WRITE_CYC(WCYC)) i_see_device (.clk(clk), .sys_rst(sys_rst),
		.link(link.device), .chip_select_bit_zero(CS[0]), .chip_select_bit_one(CS[1]),
		.chip_select_bit_two(CS[2]), .write_protect(wp), .busy(busy));
	see_master i_see_master (.clk(clk), .sys_rst(sys_rst), .link(link.master),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_select(cmd_select),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
	see_link_asserts i_see_link_asserts (.clk(clk), .sys_rst(sys_rst), .scl(link.scl),
		.sda(link.sda), .sda_m_out(link.sda_m_out), .sda_m_oe(link.sda_m_oe),
		.sda_d_out(link.sda_d_out), .sda_d_oe(link.sda_d_oe));
	always #20 clk = ~clk;
	// ====
	// Tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic op(input logic rd, input logic [2:0] sel, input see_addr_t a,
		input see_byte_t d);
		int n;
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_select = sel;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clk);
		chk("response", 8'h01, {7'h00, rsp_valid});
	endtask : op
	// Retrying until acknowledged doubles as polling for the end of a write.
	task automatic go(input logic rd, input see_addr_t a, input see_byte_t d);
		int k;
		k = 0;
		do begin
			op(rd, CS, a, d);
			k++;
		end while (rsp_nack !== 1'b0 && k < 40);
		chk("acknowledge", 8'h00, {7'h00, rsp_nack});
	endtask : go
	task automatic rd(input see_byte_t e);
		go(1'b1, 7'h00, 8'h00);
		chk("read data", e, rsp_rdata);
	endtask : rd
	task automatic busy_len();
		int   n;
		logic ok;
		for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
		for (n = 0; n < 2000 && busy === 1'b1; n++) @(negedge clk);
		ok = (n >= WCYC - 2) && (n <= WCYC + 2);
		chk("busy length ok", 8'h01, {7'h00, ok});
	endtask : busy_len
	task automatic end_of_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	// ====
	// Sequence
	initial begin
		#3000000;
		n_fail++;
		end_of_test();
	end
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		wp = 1'b0;
		n_fail = 0;
		checks = 0;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_select = CS;
		cmd_addr = 7'h00;
		cmd_wdata = 8'h00;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		op(1'b0, CS, 7'h11, 8'hC3);
		chk("write ack", 8'h00, {7'h00, rsp_nack});
		op(1'b0, CS, 7'h10, 8'hA1);
		chk("busy nack", 8'h01, {7'h00, rsp_nack});
		go(1'b0, 7'h10, 8'hA1);
		go(1'b0, 7'h1F, 8'hB2);
		busy_len();
		rd(8'hA1);
		rd(8'hC3);
		op(1'b0, 3'b100, 7'h10, 8'h00);
		chk("select nack", 8'h01, {7'h00, rsp_nack});
		op(1'b1, 3'b100, 7'h00, 8'h00);
		chk("select nack", 8'h01, {7'h00, rsp_nack});
		repeat (8) @(negedge clk);
		chk("busy", 8'h00, {7'h00, busy});
		go(1'b0, 7'h40, 8'h44);
		go(1'b0, 7'h00, 8'hE5);
		go(1'b0, 7'h7F, 8'hD4);
		go(1'b0, 7'h7E, 8'h96);
		rd(8'hD4);
		rd(8'hE5);
		wp = 1'b1;
		go(1'b0, 7'h3F, 8'h3C);
		go(1'b0, 7'h3E, 8'h3D);
		rd(8'h3C);
		go(1'b0, 7'h40, 8'h00);
		go(1'b0, 7'h4F, 8'h00);
		rd(8'h44);
		go(1'b0, 7'h7E, 8'h00);
		rd(8'hD4);
		end_of_test();
	end
endmodule : serial_eeprom_command_logic_tb
